// File: logic/ident_page_defines.vh
// Constants for the identify parameter page generator.
// Assumes inclusion by the page generator only; definitions only.
`ifndef IDENT_PAGE_DEFINES_VH
`define IDENT_PAGE_DEFINES_VH
`define W_GEN_CONFIG      16'h044A
`define W_BUFFER_TYPE     16'h0002
`define W_MULTI_MAX_HI    8'h80
`define W_CAPABILITIES    16'h0B00
`define W_PIO_TIMING      16'h0200
`define W_XLAT_VALID      16'h0007
`define W_MULTI_VALID_HI  8'h01
`define W_DMA_SUPPORTED   16'h0007
`define W_ADV_PIO         16'h0003
`define W_CYCLE_120NS     16'h0078
`define W_MAJOR_VERSION   16'h007E
`define W_MINOR_VERSION   16'h0019
`define W_FEATURES        16'h706B
`define W_SIGNATURE       8'hA5
`define SERIAL_SPACES     80'h2020_2020_2020_2020_2020
`define LAST_WORD         8'hFF
`define DMA_BIT_LO        8
`define DMA_NONE          2'h3
`define WORD_USER_SERIAL  8'h0A
`define WORD_UNIQUE_ID    8'h0F
`define WORD_FIRMWARE     8'h17
`define WORD_MODEL        8'h1B
`endif

// File: logic/identify_parameter_page.v
// Identify parameter page generator: streams the 256-word page on a
// valid/ready word port, one word per accepted handshake.
// Assumes a surrounding PIO data-in engine drains the port exactly as
// it drains a sector read, and that all inputs share i_clk.
//
// Summary of operation
// - Page uses sector-read data-in protocol; reserved bits and words read zero.
// - Word 0 reports non-magnetic, hard sectored, fixed, fast, not MFM.
// - Words 7-8 hold sector count, MSW first, equal to first invalid LBA.
// - Serial words 10-19: user ten bytes (default spaces), then preset unique ID.
// - Word 20 reports dual-ported multi-sector buffer type.
// - Word 47 reports maximum sectors per read/write-multiple interrupt.
// - Word 49 sets IORDY, LBA and DMA support bits.
// - Word 53 bits 0,1,2 mark words 54-58, 64-70 and 88 valid.
// - Words 57-58 hold current cylinders times heads times sectors.
// - Word 59 high byte is 01h; low byte is last multiple setting, reset 00h.
// - Word 63 has at most one DMA mode-selected bit set.
// - Word 63 supported bits cumulative: mode 2 implies modes 0 and 1.
// - Word 64 reports PIO modes 3 and 4; bits 7:2 zero; word 53 bit 1 set.
// - Words 65 and 66 report 120 ns multiword DMA cycle time.
// - Host faster than 120 ns may see DMA request pauses; host tolerates them.
// - Words 67 and 68 report 120 ns PIO cycle time, with and without IORDY.
// - Word 80 claims major versions 1 through 6.
// - Word 81 reports the sixth-generation minor revision code.
// - Word 82 reports the fixed feature-support set.
// - Word 255 holds signature A5h low and page checksum high.
`include "ident_page_defines.vh"

module identify_parameter_page (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rst_b,
    // Command
    input  wire         i_start,
    // Live configuration
    input  wire [15:0]  i_default_cylinders,
    input  wire [15:0]  i_default_heads,
    input  wire [15:0]  i_default_sectors,
    input  wire [31:0]  i_total_sectors,
    input  wire [15:0]  i_current_cylinders,
    input  wire [15:0]  i_current_heads,
    input  wire [15:0]  i_current_sectors,
    input  wire [7:0]   i_max_multiple,
    input  wire         i_multiple_load,
    input  wire [7:0]   i_multiple_value,
    input  wire [1:0]   i_dma_mode_sel,
    input  wire         i_user_serial_load,
    input  wire [79:0]  i_user_serial,
    input  wire [79:0]  i_unique_id,
    input  wire [63:0]  i_firmware_rev,
    input  wire [319:0] i_model_number,
    // Word stream
    input  wire         i_word_ready,
    output wire         o_word_valid,
    output reg  [15:0]  o_word_data,
    output reg  [7:0]   o_word_index,
    output wire         o_busy,
    output reg          o_done
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg         state;
    reg [7:0]   index;
    reg [7:0]   byte_sum;
    reg [7:0]   multiple_setting;
    reg [79:0]  user_serial;
    // Snapshot taken at start so the page is self-consistent
    reg [15:0]  snap_cyl;
    reg [15:0]  snap_head;
    reg [15:0]  snap_spt;
    reg [7:0]   snap_multi;
    reg [1:0]   snap_dma;

    wire [47:0] capacity_full = snap_cyl * snap_head * snap_spt;
    wire        accept        = (state == ST_SEND) && i_word_ready;
    wire [7:0]  next_index    = index + 8'h01;
    wire [7:0]  next_sum      = byte_sum + o_word_data[15:8] + o_word_data[7:0];

    reg  [15:0] dma_sel_bits;
    reg  [15:0] page_word;
    reg  [31:0] capacity;
    wire [15:0] user_serial_word;
    wire [15:0] unique_id_word;
    wire [15:0] firmware_word;
    wire [15:0] model_word;

    assign o_word_valid = (state == ST_SEND);
    assign o_busy       = (state == ST_SEND);

    always @* begin
        dma_sel_bits = 16'h0000;
        // Decoder gives one-hot or nothing, so two modes never show at once
        if (snap_dma != `DMA_NONE) begin
            dma_sel_bits[`DMA_BIT_LO + snap_dma] = 1'b1;
        end
    end

    // User serial, left half of the serial field
    ascii_field_word #(
        .WORDS (5)
    ) user_serial_pick (
        .i_field  (user_serial),
        .i_offset (next_index - `WORD_USER_SERIAL),
        .o_word   (user_serial_word)
    );

    // Preset unique value, right half of the serial field
    ascii_field_word #(
        .WORDS (5)
    ) unique_id_pick (
        .i_field  (i_unique_id),
        .i_offset (next_index - `WORD_UNIQUE_ID),
        .o_word   (unique_id_word)
    );

    // Firmware revision text
    ascii_field_word #(
        .WORDS (4)
    ) firmware_pick (
        .i_field  (i_firmware_rev),
        .i_offset (next_index - `WORD_FIRMWARE),
        .o_word   (firmware_word)
    );

    // Model number text
    ascii_field_word #(
        .WORDS (20)
    ) model_pick (
        .i_field  (i_model_number),
        .i_offset (next_index - `WORD_MODEL),
        .o_word   (model_word)
    );

    // Word content for a given address
    always @* begin
        page_word = 16'h0000;
        case (next_index)
            // Identification and default geometry
            8'h00: page_word = `W_GEN_CONFIG;
            8'h01: page_word = i_default_cylinders;
            8'h02: page_word = 16'h0000;
            8'h03: page_word = i_default_heads;
            8'h04: page_word = 16'h0000;
            8'h05: page_word = 16'h0000;
            8'h06: page_word = i_default_sectors;
            8'h07: page_word = i_total_sectors[31:16];
            8'h08: page_word = i_total_sectors[15:0];
            8'h09: page_word = 16'h0000;

            // Text fields, first character in the high byte
            8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E: page_word = user_serial_word;
            8'h0F, 8'h10, 8'h11, 8'h12, 8'h13: page_word = unique_id_word;
            8'h14: page_word = `W_BUFFER_TYPE;
            8'h15: page_word = 16'h0000;
            8'h16: page_word = 16'h0000;
            8'h17, 8'h18, 8'h19, 8'h1A: page_word = firmware_word;
            8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F,
            8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
            8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
            8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E: page_word = model_word;

            // Capabilities and current translation
            8'h2F: page_word = {`W_MULTI_MAX_HI, i_max_multiple};
            8'h30: page_word = 16'h0000;
            8'h31: page_word = `W_CAPABILITIES;
            8'h32: page_word = 16'h0000;
            8'h33: page_word = `W_PIO_TIMING;
            8'h34: page_word = 16'h0000;
            8'h35: page_word = `W_XLAT_VALID;
            8'h36: page_word = snap_cyl;
            8'h37: page_word = snap_head;
            8'h38: page_word = snap_spt;
            8'h39: page_word = capacity[15:0];
            8'h3A: page_word = capacity[31:16];
            8'h3B: page_word = {`W_MULTI_VALID_HI, snap_multi};
            8'h3C: page_word = i_total_sectors[15:0];
            8'h3D: page_word = i_total_sectors[31:16];
            8'h3E: page_word = 16'h0000;

            // Transfer modes and cycle times
            8'h3F: page_word = dma_sel_bits | `W_DMA_SUPPORTED;
            8'h40: page_word = `W_ADV_PIO;
            8'h41: page_word = `W_CYCLE_120NS;
            8'h42: page_word = `W_CYCLE_120NS;
            8'h43: page_word = `W_CYCLE_120NS;
            8'h44: page_word = `W_CYCLE_120NS;
            8'h45: page_word = 16'h0000;
            8'h46: page_word = 16'h0000;
            8'h47: page_word = 16'h0000;
            8'h48: page_word = 16'h0000;
            8'h49: page_word = 16'h0000;
            8'h4A: page_word = 16'h0000;
            8'h4B: page_word = 16'h0000;
            8'h4C: page_word = 16'h0000;
            8'h4D: page_word = 16'h0000;
            8'h4E: page_word = 16'h0000;
            8'h4F: page_word = 16'h0000;

            // Versions and features
            8'h50: page_word = `W_MAJOR_VERSION;
            8'h51: page_word = `W_MINOR_VERSION;
            8'h52: page_word = `W_FEATURES;
            // Checksum makes the sum of all 512 bytes zero
            `LAST_WORD: page_word = {8'h00 - next_sum - `W_SIGNATURE,
                                     `W_SIGNATURE};
            default: page_word = 16'h0000;
        endcase
    end

    // Registered so the three-way product has many cycles to settle
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            capacity <= 32'h0000_0000;
        end else begin
            capacity <= capacity_full[31:0];
        end
    end

    // Live settings kept across commands
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            multiple_setting <= 8'h00;
            user_serial      <= `SERIAL_SPACES;
        end else begin
            if (i_multiple_load) begin
                multiple_setting <= i_multiple_value;
            end
            if (i_user_serial_load) begin
                user_serial <= i_user_serial;
            end
        end
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state        <= ST_IDLE;
            index        <= 8'h00;
            byte_sum     <= 8'h00;
            o_word_data  <= 16'h0000;
            o_word_index <= 8'h00;
            o_done       <= 1'b0;
            snap_cyl     <= 16'h0000;
            snap_head    <= 16'h0000;
            snap_spt     <= 16'h0000;
            snap_multi   <= 8'h00;
            snap_dma     <= `DMA_NONE;
        end else begin
            o_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_start) begin
                        // Snapshot first, word 0 is constant so no hazard
                        snap_cyl     <= i_current_cylinders;
                        snap_head    <= i_current_heads;
                        snap_spt     <= i_current_sectors;
                        snap_multi   <= multiple_setting;
                        snap_dma     <= i_dma_mode_sel;
                        index        <= 8'h00;
                        byte_sum     <= 8'h00;
                        o_word_data  <= `W_GEN_CONFIG;
                        o_word_index <= 8'h00;
                        state        <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (accept) begin
                        if (index == `LAST_WORD) begin
                            state  <= ST_IDLE;
                            o_done <= 1'b1;
                        end else begin
                            index        <= next_index;
                            byte_sum     <= next_sum;
                            o_word_data  <= page_word;
                            o_word_index <= next_index;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// Picks one word of a packed text field, first word in the top bits.
// Offsets outside the field give zero, so callers may pass any address.
module ascii_field_word #(
    parameter WORDS = 5
) (
    // Field and word offset
    input  wire [16*WORDS-1:0] i_field,
    input  wire [7:0]          i_offset,
    // Selected word
    output reg  [15:0]         o_word
);

    integer k;

    always @* begin
        o_word = 16'h0000;
        for (k = 0; k < WORDS; k = k + 1) begin
            if (i_offset == k[7:0]) begin
                o_word = i_field[16*(WORDS-1-k) +: 16];
            end
        end
    end

endmodule

// File: testbench/ident_page_asserts.sv
// Checker for the identify page word stream and its fixed words.
// Assumes binding to identify_parameter_page on its single clock.
module ident_page_asserts (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_start,
    input wire logic        i_word_ready,
    input wire logic        o_word_valid,
    input wire logic [15:0] o_word_data,
    input wire logic [7:0]  o_word_index,
    input wire logic        o_busy,
    input wire logic        o_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic take = o_word_valid && i_word_ready;
    a_start_word_zero: assert property (i_start && !o_busy |=>
        o_word_valid && o_word_index == 8'h00 && o_word_data == 16'h044A) else $error("bad word 0");
    a_stall_holds: assert property (o_word_valid && !i_word_ready |=>
        o_word_valid && $stable(o_word_data) && $stable(o_word_index)) else $error("word moved");
    a_index_steps: assert property (take && o_word_index != 8'hFF |=>
        o_word_valid && o_word_index == $past(o_word_index) + 8'h01) else $error("index skip");
    a_done_ends_page: assert property (take && o_word_index == 8'hFF |=>
        o_done && !o_busy ##1 !o_done) else $error("done wrong");
    a_buffer_type: assert property (o_word_valid && o_word_index == 8'h14 |->
        o_word_data == 16'h0002) else $error("buffer type wrong");
    a_multi_flag: assert property (o_word_valid && o_word_index == 8'h3B |->
        o_word_data[15:8] == 8'h01) else $error("word 59 flag wrong");
    a_dma_mode_bits: assert property (o_word_valid && o_word_index == 8'h3F |->
        $onehot0(o_word_data[10:8]) && o_word_data[2:0] == 3'h7) else $error("word 63 wrong");
    a_cycle_time_words: assert property (
        o_word_valid && o_word_index inside {[8'h41:8'h44]} |->
        o_word_data == 16'h0078) else $error("cycle time wrong");
    a_feature_word: assert property (o_word_valid && o_word_index == 8'h52 |->
        o_word_data == 16'h706B) else $error("feature word wrong");
    a_signature_byte: assert property (o_word_valid && o_word_index == 8'hFF |->
        o_word_data[7:0] == 8'hA5) else $error("signature wrong");
endmodule

bind identify_parameter_page ident_page_asserts chk_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start), .i_word_ready(i_word_ready),
    .o_word_valid(o_word_valid), .o_word_data(o_word_data), .o_word_index(o_word_index),
    .o_busy(o_busy), .o_done(o_done));

// File: testbench/ident_host_sink.sv
// Host-side model draining the page like sector-read data.
// Assumes the bench picks a prompt or a stalling drain with i_slow.
module ident_host_sink (
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    input  wire logic        i_word_valid,
    input  wire logic [15:0] i_word_data,
    input  wire logic [7:0]  i_word_index,
    output logic             o_word_ready,
    output logic [15:0]      o_page [0:255]
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_word_ready = 1'b0;
    always @(posedge i_clk) begin
        o_word_ready <= i_slow ? ~o_word_ready : 1'b1; // Pauses tolerated
        if (i_word_valid && o_word_ready)
            o_page[i_word_index] <= i_word_data; // Same drain as a sector read
    end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the identify page generator, four pages.
// Assumes the host sink model and the bound checker are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 1'b0, i_rst_b = 1'b0, i_start = 1'b0, slow = 1'b0;
    logic        i_multiple_load = 1'b0, i_user_serial_load = 1'b0;
    logic        ready, o_word_valid, o_busy, o_done;
    logic [1:0]  i_dma_mode_sel = 2'h3, sel;
    logic [7:0]  o_word_index, mult = 8'h00;
    logic [15:0] g = 16'h0000, o_word_data, page [0:255];
    logic [79:0] user = {10{8'h20}};
    int          n_mismatch = 0, tests_run = 0;
    always #20 i_clk = ~i_clk;
    identify_parameter_page dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
        .i_default_cylinders(g), .i_default_heads(g ^ 16'h0011),
        .i_default_sectors(g ^ 16'h0022), .i_total_sectors({g, ~g}), .i_current_cylinders(g),
        .i_current_heads(g ^ 16'h0011), .i_current_sectors(g ^ 16'h0022),
        .i_max_multiple(g[7:0]), .i_multiple_load(i_multiple_load), .i_multiple_value(g[15:8]),
        .i_dma_mode_sel(i_dma_mode_sel), .i_user_serial_load(i_user_serial_load),
        .i_user_serial({5{~g}}), .i_unique_id({5{g}}), .i_firmware_rev({4{~g}}),
        .i_model_number({20{g ^ 16'h2020}}), .i_word_ready(ready), .o_word_valid(o_word_valid),
        .o_word_data(o_word_data), .o_word_index(o_word_index), .o_busy(o_busy), .o_done(o_done));
    ident_host_sink sink_u (.i_clk(i_clk), .i_slow(slow), .i_word_valid(o_word_valid),
        .i_word_data(o_word_data), .i_word_index(o_word_index), .o_word_ready(ready),
        .o_page(page));

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [15:0] exp_word(input int i);
        logic [31:0] cap;
        cap = 32'(g) * 32'(g ^ 16'h0011) * 32'(g ^ 16'h0022);
        if (i >= 10 && i <= 14) return user[239 - 16 * i -: 16];
        if (i >= 15 && i <= 19) return g;
        if (i >= 23 && i <= 26) return ~g;
        if (i >= 27 && i <= 46) return g ^ 16'h2020;
        if (i >= 65 && i <= 68) return 16'h0078;
        case (i)
            0: return 16'h044A;
            1, 7, 54, 61: return g;
            3, 55: return g ^ 16'h0011;
            6, 56: return g ^ 16'h0022;
            8, 60: return ~g;
            20: return 16'h0002;
            47: return {8'h80, g[7:0]};
            49: return 16'h0B00;
            51: return 16'h0200;
            53: return 16'h0007;
            57: return cap[15:0];
            58: return cap[31:16];
            59: return {8'h01, mult};
            63: return {5'h00, sel == 2'h2, sel == 2'h1, sel == 2'h0, 8'h07};
            64: return 16'h0003;
            80: return 16'h007E;
            81: return 16'h0019;
            82: return 16'h706B;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic run_page(input int p);
        int          t;
        logic [7:0]  sum;
        logic [15:0] w;
        @(posedge i_clk);
        g <= 16'h1357 * 16'(p + 1);
        sel = 2'(p);
        i_dma_mode_sel <= 2'(p);
        slow <= p[0];
        i_multiple_load <= (p == 1);
        i_user_serial_load <= (p == 1);
        @(posedge i_clk);
        i_multiple_load <= 1'b0;
        i_user_serial_load <= 1'b0;
        i_start <= 1'b1;
        if (p == 1) begin
            mult = g[15:8];
            user = {5{~g}};
        end
        @(posedge i_clk);
        i_start <= 1'b0;
        repeat (20) @(posedge i_clk);
        // Mid-page selection change and start must not reach this page
        i_dma_mode_sel <= 2'(p + 1);
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        for (t = 0; t < 800 && o_done !== 1'b1; t++) begin
            @(posedge i_clk);
            #1;
        end
        if (t == 800) begin
            n_mismatch++;
            $display("[ERR] page %0d done expected 1 seen 0", p);
        end else begin
            sum = 8'hA5;
            for (int i = 0; i < 255; i++) begin
                w = exp_word(i);
                sum = sum + w[15:8] + w[7:0];
                check($sformatf("word %0d", i), page[i], w);
            end
            check("word 255", page[255], {8'h00 - sum, 8'hA5});
        end
    endtask

    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            if (p == 3) begin
                @(posedge i_clk);
                i_rst_b <= 1'b0;
                repeat (8) @(posedge i_clk);
                i_rst_b <= 1'b1;
                mult = 8'h00;
                user = {10{8'h20}};
            end
            run_page(p);
        end
        finish_test();
    end
endmodule
